// file: core/supply_reset_pkg.sv
// Package for the supply, reset and startup controller.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package supply_reset_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_TRIM = 8'h10;
  localparam logic [7:0] OFF_SWRST = 8'h14;
  localparam logic [7:0] OFF_LPM = 8'h18;
  // Mode register fields
  localparam int BOD_DIS_BIT = 0;
  localparam int SMON_EN_BIT = 1;
  localparam int SMON_SMPL_BIT = 2;
  localparam int XTAL_EN_BIT = 3;
  localparam int SCLK_SEL_BIT = 4;
  localparam int SMON_TH_LSB = 8;
  localparam int SMON_TH_W = 4;
  localparam int SMON_RATE_LSB = 12;
  localparam int SMON_RATE_W = 4;
  localparam logic [3:0] SMON_RATE_MAX = 4'hb;
  localparam int FRC_SEL_LSB = 16;
  localparam int FRC_SEL_W = 2;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK = 32'h0003_ff1f;
  // Fast RC frequency codes
  localparam logic [1:0] FRC_4MHZ = 2'h0;
  localparam logic [1:0] FRC_8MHZ = 2'h1;
  localparam logic [1:0] FRC_12MHZ = 2'h2;
  localparam logic [1:0] FRC_RSVD = 2'h3;
  // Trim fields
  localparam int TRIM_W = 8;
  localparam int TRIM8_LSB = 0;
  localparam int TRIM12_LSB = 8;
  localparam logic [15:0] TRIM_RST = 16'h8080;
  // Software reset key
  localparam logic [31:0] SWRST_KEY = 32'ha500_0001;
  // Status / mask bits
  localparam int EV_W = 4;
  localparam int EV_SMON = 0;
  localparam int EV_BOD = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_PIN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset pulse and startup timing, slow clock cycles at 32 kHz
  localparam int SCLK_HZ = 32000;
  localparam int PIN_PULSE_US = 2000;
  localparam int PIN_PULSE_CYC = (PIN_PULSE_US * SCLK_HZ) / 1000000;
  localparam int STEP_US = 100;
  localparam int STEP_CYC = ((STEP_US * SCLK_HZ) + 999999) / 1000000;
  localparam int NWAKE = 16;

  typedef enum logic [2:0]
  {
    CAUSE_GENERAL = 3'h0,
    CAUSE_WAKEUP = 3'h1,
    CAUSE_WATCHDOG = 3'h2,
    CAUSE_SOFTWARE = 3'h3,
    CAUSE_USER = 3'h4
  } cause_t;

  typedef enum logic [2:0]
  {
    ST_OFF = 3'h0,
    ST_SWITCH = 3'h1,
    ST_REG = 3'h2,
    ST_RUN = 3'h3,
    ST_LOWPWR = 3'h4
  } seq_t;

  typedef struct packed
  {
    logic switch_en;
    logic regulator_en;
    logic core_rst_n;
  } power_ctl_t;
endpackage

// file: core/supply_reset_startup_control.sv
// Supply, reset and startup controller with an AXI4-Lite register slave.
// Clocked by the 32 kHz slow clock; monitor and pin inputs are asynchronous.
// Functional notes
// - Power-on reset low resets whole chip
// - Brownout detector enabled after reset, disableable
// - Enabled brownout low asserts core reset
// - Supply monitor off by default, 16 thresholds
// - Sampled monitor mode, duty down to 2048
// - Record last reset cause for software
// - Sense and drive shaped reset pin pulse
// - Reset config held in I/O supply domain
// - Runs on slow clock, own power-on reset
// - Slow clock starts on RC, crystal selectable
// - Unused RC oscillator disabled automatically when crystal selected; crystal follows its enable bit
// - Switches, then regulator, then release core reset
// - One low-power mode with wake-up events
// - Sixteen fast-startup sources from wake-up pins
// - Fast RC 4/8/12 MHz, resets to 4
// - Software trim for 8 and 12 MHz
`timescale 1ns/1ps
module supply_reset_startup_control #(
  parameter int PULSE_CYC = supply_reset_pkg::PIN_PULSE_CYC,
  parameter int STEP_CYCLES = supply_reset_pkg::STEP_CYC
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic io_supply_low,
  input wire logic core_supply_low,
  input wire logic smon_below,
  input wire logic watchdog_fault,
  input wire logic [15:0] wakeup_pins,
  input wire logic external_reset_pin_i,
  output logic external_reset_pin_o,
  output logic external_reset_pin_oe,
  output logic chip_rst_n,
  output supply_reset_pkg::power_ctl_t power_ctl,
  output logic smon_en,
  output logic [3:0] smon_threshold,
  output logic bod_en,
  output logic rc_osc_en,
  output logic xtal_osc_en,
  output logic slow_clk_sel,
  output logic [1:0] fast_rc_sel,
  output logic [15:0] fast_rc_trim,
  output logic [15:0] fast_startup_sources,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Two-flop synchronisers for asynchronous inputs
  localparam int NSYNC = 21;
  // Reset pin idles high, so its stages reset high: no false edge after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 21'h00_0010;
  logic [NSYNC-1:0] sync1_ff, sync2_ff;
  wire [NSYNC-1:0] async_in = {wakeup_pins, external_reset_pin_i, watchdog_fault,
                               smon_below, core_supply_low, io_supply_low};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
    end
    else if (clk_en)
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end
  wire io_low_s = sync2_ff[0];
  wire core_low_s = sync2_ff[1];
  wire smon_below_s = sync2_ff[2];
  wire wdt_s = sync2_ff[3];
  wire pin_low_s = ~sync2_ff[4];
  wire [15:0] wake_s = sync2_ff[20:5];

  // Registers
  logic [31:0] mode_ff, nxt_mode;
  logic [15:0] trim_ff, nxt_trim;
  logic [3:0] status_ff, nxt_status;
  logic [3:0] mask_ff, nxt_mask;
  logic [15:0] wake_en_ff, nxt_wake_en;
  logic lpm_req_ff;
  supply_reset_pkg::cause_t cause_ff, nxt_cause;
  supply_reset_pkg::seq_t seq_ff, nxt_seq;
  logic [15:0] step_cnt_ff;
  logic [15:0] pulse_cnt_ff;
  logic [10:0] smpl_cnt_ff;
  logic pin_drive_ff;
  logic pin_low_d_ff;
  logic sw_rst_ff;

  // AXI handshake state
  logic aw_full_ff, w_full_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  wire aw_take = s_axi_awvalid && !aw_full_ff;
  wire w_take = s_axi_wvalid && !w_full_ff;
  wire wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire wr_mode = wr_go && aw_addr_ff == supply_reset_pkg::OFF_MODE;
  wire wr_mask = wr_go && aw_addr_ff == supply_reset_pkg::OFF_MASK;
  wire wr_trim = wr_go && aw_addr_ff == supply_reset_pkg::OFF_TRIM;
  wire wr_swrst = wr_go && aw_addr_ff == supply_reset_pkg::OFF_SWRST;
  wire wr_lpm = wr_go && aw_addr_ff == supply_reset_pkg::OFF_LPM;
  wire wr_ok = wr_mode | wr_mask | wr_trim | wr_swrst | wr_lpm |
               (wr_go && aw_addr_ff == supply_reset_pkg::OFF_CAUSE) |
               (wr_go && aw_addr_ff == supply_reset_pkg::OFF_STATUS);
  wire rd_status = rd_go && s_axi_araddr == supply_reset_pkg::OFF_STATUS;
  wire [31:0] wr_val = apply_strb(32'h0000_0000, w_data_ff, w_strb_ff);

  // Mode decode
  wire bod_on = ~mode_ff[supply_reset_pkg::BOD_DIS_BIT];
  wire smon_on = mode_ff[supply_reset_pkg::SMON_EN_BIT];
  wire smon_smpl = mode_ff[supply_reset_pkg::SMON_SMPL_BIT];
  wire [3:0] smon_rate = mode_ff[supply_reset_pkg::SMON_RATE_LSB +: supply_reset_pkg::SMON_RATE_W];
  wire xtal_sel = mode_ff[supply_reset_pkg::SCLK_SEL_BIT]
                  && mode_ff[supply_reset_pkg::XTAL_EN_BIT];
  // Sample window: active one cycle of every 2^rate, capped at 2048
  wire [3:0] rate_cap = smon_rate > supply_reset_pkg::SMON_RATE_MAX
                        ? supply_reset_pkg::SMON_RATE_MAX : smon_rate;
  wire [10:0] smpl_mask = 11'((32'h1 << rate_cap) - 32'h1);
  wire smon_active = smon_on && (!smon_smpl || (smpl_cnt_ff & smpl_mask) == 11'h000);
  wire smon_event = smon_active && smon_below_s;
  wire bod_trip = bod_on && core_low_s;
  wire wdt_trip = wdt_s;
  // Own pulse reaches the synchroniser late: ignore the pin until oe drops
  wire pin_fall = pin_low_s && !pin_low_d_ff && !pin_drive_ff && !external_reset_pin_oe;
  wire [15:0] wake_hit = wake_s & wake_en_ff;
  wire wake_ev = seq_ff == supply_reset_pkg::ST_LOWPWR && |wake_hit;
  wire core_reset_req = bod_trip | wdt_trip | sw_rst_ff | pin_fall;
  wire [3:0] events = {pin_fall, wake_ev, bod_trip, smon_event};
  wire step_done = step_cnt_ff >= 16'(STEP_CYCLES - 1);

  always_comb
  begin
    nxt_mode = mode_ff;
    if (wr_mode)
      nxt_mode = apply_strb(mode_ff, w_data_ff, w_strb_ff) & supply_reset_pkg::MODE_WMASK;
    nxt_mask = wr_mask ? wr_val[3:0] : mask_ff;
    nxt_trim = wr_trim ? 16'(apply_strb({16'h0000, trim_ff}, w_data_ff, w_strb_ff))
               : trim_ff;
    nxt_wake_en = wr_lpm ? wr_val[31:16] : wake_en_ff;
    // Set beats the clear on read
    nxt_status = (rd_status ? 4'h0 : status_ff) | events;
    nxt_cause = cause_ff;
    if (seq_ff == supply_reset_pkg::ST_RUN && core_reset_req)
    begin
      if (wdt_trip)
        nxt_cause = supply_reset_pkg::CAUSE_WATCHDOG;
      else if (sw_rst_ff)
        nxt_cause = supply_reset_pkg::CAUSE_SOFTWARE;
      else if (pin_fall)
        nxt_cause = supply_reset_pkg::CAUSE_USER;
      else
        nxt_cause = supply_reset_pkg::CAUSE_GENERAL;
    end
    else if (wake_ev)
      nxt_cause = supply_reset_pkg::CAUSE_WAKEUP;
    nxt_seq = seq_ff;
    case (seq_ff)
      supply_reset_pkg::ST_OFF:
        nxt_seq = supply_reset_pkg::ST_SWITCH;
      supply_reset_pkg::ST_SWITCH:
        nxt_seq = step_done ? supply_reset_pkg::ST_REG : seq_ff;
      supply_reset_pkg::ST_REG:
        nxt_seq = step_done ? supply_reset_pkg::ST_RUN : seq_ff;
      supply_reset_pkg::ST_RUN:
        if (core_reset_req)
          nxt_seq = supply_reset_pkg::ST_REG;
        else if (lpm_req_ff)
          nxt_seq = supply_reset_pkg::ST_LOWPWR;
      supply_reset_pkg::ST_LOWPWR:
        nxt_seq = wake_ev ? supply_reset_pkg::ST_SWITCH : seq_ff;
      default:
        nxt_seq = supply_reset_pkg::ST_OFF;
    endcase
  end

  // Power-on reset of the whole chip and own reset
  wire por_n = aresetn && !io_low_s;

  always_ff @(posedge aclk)
  begin
    if (!por_n)
    begin
      mode_ff <= supply_reset_pkg::MODE_RST;
      trim_ff <= supply_reset_pkg::TRIM_RST;
      cause_ff <= supply_reset_pkg::CAUSE_GENERAL;
      seq_ff <= supply_reset_pkg::ST_OFF;
      status_ff <= '0;
      mask_ff <= '0;
      wake_en_ff <= '0;
      lpm_req_ff <= 1'b0;
      sw_rst_ff <= 1'b0;
      step_cnt_ff <= '0;
      pulse_cnt_ff <= '0;
      pin_drive_ff <= 1'b0;
      pin_low_d_ff <= 1'b0;
      smpl_cnt_ff <= '0;
    end
    else if (clk_en)
    begin
      mode_ff <= nxt_mode;
      trim_ff <= nxt_trim;
      cause_ff <= nxt_cause;
      seq_ff <= nxt_seq;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      wake_en_ff <= nxt_wake_en;
      lpm_req_ff <= wr_lpm ? wr_val[0]
                    : (nxt_seq == supply_reset_pkg::ST_LOWPWR ? 1'b0 : lpm_req_ff);
      sw_rst_ff <= wr_swrst && w_data_ff == supply_reset_pkg::SWRST_KEY;
      step_cnt_ff <= nxt_seq != seq_ff || step_done ? 16'h0000 : step_cnt_ff + 16'h0001;
      pin_low_d_ff <= pin_low_s;
      smpl_cnt_ff <= smpl_cnt_ff + 11'h001;
      // Shaped outgoing pulse on any core reset request while in ST_RUN
      if (seq_ff == supply_reset_pkg::ST_RUN && core_reset_req)
      begin
        pin_drive_ff <= 1'b1;
        pulse_cnt_ff <= 16'(PULSE_CYC);
      end
      else if (pulse_cnt_ff != 16'h0000)
        pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
      else
        pin_drive_ff <= 1'b0;
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= supply_reset_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= supply_reset_pkg::RESP_OKAY;
      rdata_ff <= '0;
    end
    else if (clk_en)
    begin
      if (aw_take)
      begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? supply_reset_pkg::RESP_OKAY : supply_reset_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
      if (rd_go)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= supply_reset_pkg::RESP_OKAY;
        case (s_axi_araddr)
          supply_reset_pkg::OFF_MODE: rdata_ff <= mode_ff;
          supply_reset_pkg::OFF_CAUSE: rdata_ff <= {29'h0, cause_ff};
          supply_reset_pkg::OFF_STATUS: rdata_ff <= {28'h0, status_ff};
          supply_reset_pkg::OFF_MASK: rdata_ff <= {28'h0, mask_ff};
          supply_reset_pkg::OFF_TRIM: rdata_ff <= {16'h0, trim_ff};
          supply_reset_pkg::OFF_SWRST: rdata_ff <= 32'h0000_0000;
          supply_reset_pkg::OFF_LPM: rdata_ff <= {wake_en_ff, 13'h0, seq_ff};
          default:
          begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= supply_reset_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge aclk)
  begin
    if (!por_n)
    begin
      chip_rst_n <= 1'b0;
      power_ctl <= '0;
      smon_en <= 1'b0;
      smon_threshold <= '0;
      bod_en <= 1'b1;
      rc_osc_en <= 1'b1;
      xtal_osc_en <= 1'b0;
      slow_clk_sel <= 1'b0;
      fast_rc_sel <= supply_reset_pkg::FRC_4MHZ;
      fast_rc_trim <= supply_reset_pkg::TRIM_RST;
      fast_startup_sources <= '0;
      external_reset_pin_o <= 1'b0;
      external_reset_pin_oe <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      chip_rst_n <= 1'b1;
      power_ctl.switch_en <= seq_ff != supply_reset_pkg::ST_OFF;
      power_ctl.regulator_en <= seq_ff == supply_reset_pkg::ST_REG
                                || seq_ff == supply_reset_pkg::ST_RUN;
      power_ctl.core_rst_n <= seq_ff == supply_reset_pkg::ST_RUN && !core_reset_req;
      smon_en <= smon_active;
      smon_threshold <= mode_ff[supply_reset_pkg::SMON_TH_LSB +: supply_reset_pkg::SMON_TH_W];
      bod_en <= bod_on;
      xtal_osc_en <= mode_ff[supply_reset_pkg::XTAL_EN_BIT];
      rc_osc_en <= !xtal_sel;
      slow_clk_sel <= xtal_sel;
      fast_rc_sel <= mode_ff[supply_reset_pkg::FRC_SEL_LSB +: supply_reset_pkg::FRC_SEL_W] ==
                     supply_reset_pkg::FRC_RSVD ? supply_reset_pkg::FRC_4MHZ :
                     mode_ff[supply_reset_pkg::FRC_SEL_LSB +: supply_reset_pkg::FRC_SEL_W];
      fast_rc_trim <= trim_ff;
      fast_startup_sources <= wake_hit;
      external_reset_pin_o <= 1'b0;
      external_reset_pin_oe <= pin_drive_ff;
      irq <= |(status_ff & mask_ff);
    end
  end

  assign s_axi_awready = !aw_full_ff;
  assign s_axi_wready = !w_full_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule

// file: testbench/supply_reset_properties.sv
// Checker on the controller's outputs, bound from the bench top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module supply_reset_properties #(
  parameter int PULSE_CYC = 2
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic io_supply_low,
  input wire logic core_supply_low,
  input wire logic [15:0] wakeup_pins,
  input wire logic external_reset_pin_o,
  input wire logic external_reset_pin_oe,
  input wire logic chip_rst_n,
  input wire supply_reset_pkg::power_ctl_t power_ctl,
  input wire logic smon_en,
  input wire logic bod_en,
  input wire logic rc_osc_en,
  input wire logic xtal_osc_en,
  input wire logic slow_clk_sel,
  input wire logic [1:0] fast_rc_sel,
  input wire logic [15:0] fast_startup_sources
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  int drive_cnt;
  always_ff @(posedge aclk)
  begin
    drive_cnt <= external_reset_pin_oe ? drive_cnt + 1 : 0;
  end
  sequence s_reg_rise;
    !power_ctl.regulator_en ##1 power_ctl.regulator_en;
  endsequence
  sequence s_core_release;
    !power_ctl.core_rst_n ##1 power_ctl.core_rst_n;
  endsequence
  a_reset_defaults: assert property (disable iff (1'b0) !aresetn |=>
    bod_en && !smon_en && rc_osc_en && fast_rc_sel == 2'h0)
    else $error("defaults wrong after reset");
  a_por_chip_reset: assert property (io_supply_low [*5] |->
    !chip_rst_n && power_ctl == 3'h0) else $error("chip reset missing");
  a_bod_core_reset: assert property ((bod_en && core_supply_low) [*6] |->
    !power_ctl.core_rst_n) else $error("core reset missing");
  a_reg_after_switch: assert property (s_reg_rise |->
    $past(power_ctl.switch_en)) else $error("regulator before switch");
  a_core_after_reg: assert property (s_core_release |->
    $past(power_ctl.switch_en && power_ctl.regulator_en)) else $error("core released early");
  a_rc_kept_on: assert property (!slow_clk_sel [*2] |-> rc_osc_en)
    else $error("rc oscillator off");
  a_unused_osc_off: assert property (slow_clk_sel [*2] |->
    !rc_osc_en && xtal_osc_en) else $error("unused oscillator on");
  a_quiet_wake_pins: assert property ((wakeup_pins == 16'h0) [*4] |->
    fast_startup_sources == 16'h0) else $error("startup source without pin");
  a_pin_open_drain: assert property (external_reset_pin_oe |-> !external_reset_pin_o)
    else $error("pin driven high");
  a_pin_pulse_len: assert property ($fell(external_reset_pin_oe) |->
    $past(drive_cnt) >= PULSE_CYC) else $error("pin pulse too short");
endmodule

// file: testbench/reset_pin_partner.sv
// Push-button and listening devices on the open-drain reset pin.
// Assumes a pull-up on the wire; measures each pulse the block drives.
`timescale 1ns/1ps
module reset_pin_partner (
  input wire logic clk,
  input wire logic pin_oe,
  input wire logic pin_o,
  input wire logic press,
  output logic pin_level,
  output int low_len
);
  int run = 0;
  initial low_len = 0;
  // Pulled up unless the block or the button pulls low
  assign pin_level = ((pin_oe && !pin_o) || press) ? 1'b0 : 1'b1;
  always @(posedge clk)
  begin
    if (pin_oe)
      run <= run + 1;
    else if (run != 0)
    begin
      low_len <= run;
      run <= 0;
    end
  end
endmodule

// file: testbench/tb.sv
// Self-checking bench: AXI4-Lite register tasks plus supply events.
// Assumes the controller, its package, the checker and the pin partner.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] M = supply_reset_pkg::OFF_MODE;
  localparam logic [7:0] C = supply_reset_pkg::OFF_CAUSE;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic io_low = 1'b0;
  logic core_low = 1'b0;
  logic smon_below = 1'b0;
  logic wdog = 1'b0;
  logic press = 1'b0;
  logic [15:0] wk = 16'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_lvl, chip_rst_n;
  logic smon_en, bod_en, rc_en, xt_en, sclk_sel, irq;
  logic [1:0] bresp, rresp, frc;
  logic [3:0] thr;
  logic [15:0] trim, fss;
  logic [31:0] rdata, d;
  supply_reset_pkg::power_ctl_t pwr;
  int n_mismatch = 0;
  int checked = 0;
  int low_len, cnt, tmo = 0;
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  supply_reset_startup_control #(.PULSE_CYC(2), .STEP_CYCLES(1)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .io_supply_low(io_low),
    .core_supply_low(core_low), .smon_below(smon_below), .watchdog_fault(wdog),
    .wakeup_pins(wk), .external_reset_pin_i(pin_lvl), .external_reset_pin_o(pin_o),
    .external_reset_pin_oe(pin_oe), .chip_rst_n(chip_rst_n), .power_ctl(pwr),
    .smon_en(smon_en), .smon_threshold(thr), .bod_en(bod_en), .rc_osc_en(rc_en),
    .xtal_osc_en(xt_en), .slow_clk_sel(sclk_sel), .fast_rc_sel(frc),
    .fast_rc_trim(trim), .fast_startup_sources(fss), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  reset_pin_partner i_pin (.clk(aclk), .pin_oe(pin_oe), .pin_o(pin_o), .press(press),
    .pin_level(pin_lvl), .low_len(low_len));
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    v = (rresp === supply_reset_pkg::RESP_OKAY) ? rdata : 32'hdead_0000;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic core_up();
    cnt = 0;
    while (pwr.core_rst_n !== 1'b1 && cnt < 300)
    begin
      cyc(1);
      cnt++;
    end
    chk(pwr, 3'h7);
    cyc(1);
  endtask
  always @(posedge aclk)
  begin
    tmo <= tmo + 1;
    if (tmo == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    cyc(5);
    aresetn <= 1'b1;
    core_up();
    chk({bod_en, smon_en, rc_en, xt_en, frc}, 6'h28);
    rd(M, d);
    chk(d, supply_reset_pkg::MODE_RST);
    rd(supply_reset_pkg::OFF_TRIM, d);
    chk(d, 32'h8080);
    wr(C, 32'h4);
    rd(C, d);
    chk(d, supply_reset_pkg::CAUSE_GENERAL);
    rd(8'h40, d);
    chk(d, 32'hdead_0000);
    for (int t = 0; t < 16; t++)
    begin
      wr(M, 32'h2 | (t << 8));
      cyc(2);
      chk({smon_en, thr}, 5'h10 | t);
    end
    for (int f = 0; f < 3; f++)
    begin
      wr(M, f << 16);
      cyc(2);
      chk(frc, f);
    end
    wr(supply_reset_pkg::OFF_TRIM, 32'h3c5a);
    cyc(2);
    chk(trim, 16'h3c5a);
    wr(M, 32'h1008);
    wr(M, 32'h1018);
    cyc(3);
    chk({sclk_sel, rc_en, xt_en}, 3'h5);
    cnt = 0;
    wr(M, 32'h1006);
    repeat (64)
    begin
      cyc(1);
      cnt += smon_en;
    end
    chk(cnt, 32);
    smon_below <= 1'b1;
    cyc(4);
    smon_below <= 1'b0;
    cyc(4);
    rd(supply_reset_pkg::OFF_STATUS, d);
    chk(d, 32'h1);
    wr(M, 32'h1);
    core_low <= 1'b1;
    cyc(8);
    chk({bod_en, pwr.core_rst_n}, 2'h1);
    core_low <= 1'b0;
    wr(supply_reset_pkg::OFF_MASK, 32'h2);
    wr(M, 32'h0);
    core_low <= 1'b1;
    cyc(8);
    chk(pwr.core_rst_n, 1'b0);
    core_low <= 1'b0;
    core_up();
    chk(irq, 1'b1);
    rd(supply_reset_pkg::OFF_STATUS, d);
    chk(d, 32'h2);
    cyc(3);
    chk(irq, 1'b0);
    wr(M, 32'h0300);
    wr(supply_reset_pkg::OFF_SWRST, supply_reset_pkg::SWRST_KEY);
    core_up();
    rd(C, d);
    chk(d, supply_reset_pkg::CAUSE_SOFTWARE);
    rd(M, d);
    chk(d, 32'h0300);
    press <= 1'b1;
    cyc(4);
    press <= 1'b0;
    cyc(10);
    core_up();
    rd(C, d);
    chk(d, supply_reset_pkg::CAUSE_USER);
    chk(low_len >= 2, 1'b1);
    wdog <= 1'b1;
    cyc(4);
    wdog <= 1'b0;
    core_up();
    rd(C, d);
    chk(d, supply_reset_pkg::CAUSE_WATCHDOG);
    wr(M, 32'h0301);
    wr(supply_reset_pkg::OFF_LPM, 32'hffff_0001);
    cyc(10);
    wk <= 16'h0020;
    cyc(4);
    chk(fss, 16'h0020);
    wk <= 16'h0;
    core_up();
    rd(C, d);
    chk(d, supply_reset_pkg::CAUSE_WAKEUP);
    io_low <= 1'b1;
    cyc(8);
    chk({chip_rst_n, bod_en}, 2'h1);
    io_low <= 1'b0;
    core_up();
    rd(M, d);
    chk(d, supply_reset_pkg::MODE_RST);
    end_sim();
  end
endmodule
bind supply_reset_startup_control supply_reset_properties #(.PULSE_CYC(PULSE_CYC)) i_props (
  .aclk(aclk), .aresetn(aresetn), .io_supply_low(io_supply_low),
  .core_supply_low(core_supply_low), .wakeup_pins(wakeup_pins),
  .external_reset_pin_o(external_reset_pin_o), .external_reset_pin_oe(external_reset_pin_oe),
  .chip_rst_n(chip_rst_n), .power_ctl(power_ctl), .smon_en(smon_en), .bod_en(bod_en),
  .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en), .slow_clk_sel(slow_clk_sel),
  .fast_rc_sel(fast_rc_sel), .fast_startup_sources(fast_startup_sources));
